// File: shared/pdb_defines.svh
// Constants of the dead-band generator: offsets, widths, reset values.
`ifndef PDB_DEFINES_SVH
`define PDB_DEFINES_SVH

// ************************************************************
// Register bus geometry
// ************************************************************
`define PDB_ADDR_W      12
`define PDB_DATA_W      32

// ************************************************************
// Register offsets (byte addresses)
// ************************************************************
`define PDB_CTL_OFF     12'h068
`define PDB_RISE_OFF    12'h06C
`define PDB_FALL_OFF    12'h070

// ************************************************************
// Fields and reset values
// ************************************************************
`define PDB_EN_BIT      0
`define PDB_DLY_W       12
`define PDB_CTL_RST     1'h0
`define PDB_DLY_RST     12'h000
`define PDB_CNT_MAX     12'hFFF
`define PDB_CTL_PAD     31'h00000000
`define PDB_DLY_PAD     20'h00000
`define PDB_RD_IDLE     32'h00000000

`endif

// File: shared/pdb_pkg.sv
// Types shared by the dead-band generator modules.
`include "pdb_defines.svh"
`default_nettype none

package pdb_pkg;

	// ************************************************************
	// State of the top module
	// ************************************************************
	typedef struct packed {
		logic                     enable;
		logic [`PDB_DLY_W-1:0]    rise_dly;
		logic [`PDB_DLY_W-1:0]    fall_dly;
		logic                     out_zero;
		logic                     out_one;
		logic [`PDB_DATA_W-1:0]   rdata;
	} pdb_top_s;

	// ************************************************************
	// State of one edge delay stage
	// ************************************************************
	typedef struct packed {
		logic [`PDB_DLY_W-1:0]    cnt;
	} pdb_edge_s;

endpackage : pdb_pkg

`default_nettype wire

// File: shared/pdb_edge_if.sv
// Link between the top module and one edge delay stage.
`include "pdb_defines.svh"
`default_nettype none

interface pdb_edge_if;
	logic                     sig;
	logic [`PDB_DLY_W-1:0]    dly;
	logic                     lvl;

	// Top drives the source and the delay, reads the delayed level
	modport owner  (output sig, output dly, input lvl);
	modport worker (input sig, input dly, output lvl);
endinterface : pdb_edge_if

`default_nettype wire

// File: verilog/pdb_edge_delay.sv
// One edge delay stage: holds back edges toward ACT_LEVEL by a count.
`include "pdb_defines.svh"
`default_nettype none

module pdb_edge_delay #(
	parameter bit ACT_LEVEL = 1'b1
) (
	input  wire logic   clk,
	input  wire logic   rst,
	pdb_edge_if.worker  lnk
);

	pdb_pkg::pdb_edge_s st;
	pdb_pkg::pdb_edge_s nxt_st;

	// ************************************************************
	// Dwell counter
	// ************************************************************
	// Counts cycles the source has stayed at the active level; any
	// return to the idle level clears it, cancelling a pending edge
	always_comb begin
		nxt_st = st;
		if (lnk.sig != ACT_LEVEL) begin
			nxt_st.cnt = `PDB_DLY_RST; // RULE14
		end else if (st.cnt != `PDB_CNT_MAX) begin
			nxt_st.cnt = st.cnt + `PDB_DLY_W'(1); // Saturates, no wrap
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st.cnt <= `PDB_DLY_RST;
		end else begin
			st <= nxt_st;
		end
	end

	// Active level only once the dwell reaches the delay; a pulse no
	// longer than the delay never shows on the output
	assign lnk.lvl = ((lnk.sig == ACT_LEVEL) && (st.cnt >= lnk.dly)) ? ACT_LEVEL : ~ACT_LEVEL; // RULE3 RULE4 RULE9 RULE10

endmodule : pdb_edge_delay

`default_nettype wire

// File: verilog/pdb_dead_band.sv
// Dead-band generator for one PWM pair, with its register port.
//
// Behaviour
// (RULE1) Disabled: A to output zero, B to one
// (RULE2) Enabled: B ignored, both outputs from A
// (RULE3) Output zero delays A rising edges
// (RULE4) Output one delays A falling edges
// (RULE5) Control bit 0 enables dead band, resets 0
// (RULE6) Rise delay register, 12-bit, resets zero
// (RULE7) Fall delay register, 12-bit, resets zero
// (RULE8) Disabled: delay registers have no effect
// (RULE9) Rise delay swallows short high pulses
// (RULE10) Fall delay swallows short low pulses
// (RULE11) Software keeps rise delay below high times
// (RULE12) Software keeps fall delay below low times
// (RULE13) Reserved upper bits: do not rely, never write
// (RULE14) Pending edge cancelled when A reverts early
//
// The implementer's own choice: the strobed register port.
`include "pdb_defines.svh"
`default_nettype none

module pdb_dead_band (
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire logic [`PDB_ADDR_W-1:0]   reg_addr,
	input  wire logic [`PDB_DATA_W-1:0]   reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output var  logic [`PDB_DATA_W-1:0]   reg_rdata,
	input  wire logic                     generator_signal_a,
	input  wire logic                     generator_signal_b,
	output var  logic                     output_zero,
	output var  logic                     output_one
);

	pdb_pkg::pdb_top_s st;
	pdb_pkg::pdb_top_s nxt_st;

	pdb_edge_if rise_lnk ();
	pdb_edge_if fall_lnk ();

	// ************************************************************
	// Edge delay stages
	// ************************************************************
	// Both stages watch A only; B never reaches them
	assign rise_lnk.sig = generator_signal_a; // RULE2
	assign rise_lnk.dly = st.rise_dly;
	assign fall_lnk.sig = generator_signal_a; // RULE2
	assign fall_lnk.dly = st.fall_dly;

	// Rising edges held back for output zero
	pdb_edge_delay #(
		.ACT_LEVEL (1'b1)
	) u_rise (
		.clk (clk),
		.rst (rst),
		.lnk (rise_lnk.worker)
	);

	// Falling edges held back for output one
	pdb_edge_delay #(
		.ACT_LEVEL (1'b0)
	) u_fall (
		.clk (clk),
		.rst (rst),
		.lnk (fall_lnk.worker)
	);

	// ************************************************************
	// Next state
	// ************************************************************
	// Register writes, output selection and read data in one place.
	// The stages keep counting while disabled, so a switch to enabled
	// acts on the true dwell of A rather than on a stale count.
	always_comb begin
		nxt_st = st;
		nxt_st.rdata = `PDB_RD_IDLE;

		// Register writes; only the documented field bits are stored
		if (reg_wr) begin
			case (reg_addr)
				`PDB_CTL_OFF: begin
					nxt_st.enable = reg_wdata[`PDB_EN_BIT]; // RULE5
				end
				`PDB_RISE_OFF: begin
					nxt_st.rise_dly = reg_wdata[`PDB_DLY_W-1:0]; // RULE6
				end
				`PDB_FALL_OFF: begin
					nxt_st.fall_dly = reg_wdata[`PDB_DLY_W-1:0]; // RULE7
				end
				default: begin
					nxt_st.enable = st.enable; // Unmapped writes are dropped
				end
			endcase
		end

		// Read data for the next cycle only; reserved bits read zero
		if (reg_rd) begin
			case (reg_addr)
				`PDB_CTL_OFF: begin
					nxt_st.rdata = {`PDB_CTL_PAD, st.enable}; // RULE13
				end
				`PDB_RISE_OFF: begin
					nxt_st.rdata = {`PDB_DLY_PAD, st.rise_dly}; // RULE13
				end
				`PDB_FALL_OFF: begin
					nxt_st.rdata = {`PDB_DLY_PAD, st.fall_dly}; // RULE13
				end
				default: begin
					nxt_st.rdata = `PDB_RD_IDLE; // Unmapped reads return zero
				end
			endcase
		end

		// Output selection: pass-through ignores the delays entirely
		if (st.enable) begin
			nxt_st.out_zero = rise_lnk.lvl; // RULE3
			nxt_st.out_one  = fall_lnk.lvl; // RULE4
		end else begin
			nxt_st.out_zero = generator_signal_a; // RULE1 RULE8
			nxt_st.out_one  = generator_signal_b; // RULE1 RULE8
		end
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			st.enable   <= `PDB_CTL_RST;
			st.rise_dly <= `PDB_DLY_RST;
			st.fall_dly <= `PDB_DLY_RST;
			st.out_zero <= 1'h0;
			st.out_one  <= 1'h0;
			st.rdata    <= `PDB_RD_IDLE;
		end else begin
			st <= nxt_st;
		end
	end

	// Outputs straight from the state register, so the pins never glitch
	assign reg_rdata   = st.rdata;
	assign output_zero = st.out_zero;
	assign output_one  = st.out_one;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// Disabled: output zero copies A one cycle later
	a_pass_a_zero: assert property ( // RULE1
		!st.enable |=> output_zero == $past(generator_signal_a)
	) else $error("output zero did not follow A in pass-through");

	// Disabled: output one copies B one cycle later
	a_pass_b_one: assert property ( // RULE1
		!st.enable |=> output_one == $past(generator_signal_b)
	) else $error("output one did not follow B in pass-through");

	// Enabled: A high forces output one high whatever B does
	a_ignore_b_high: assert property ( // RULE2
		st.enable && generator_signal_a && !generator_signal_b |=> output_one
	) else $error("output one took B while dead band enabled");

	// Enabled: A low drops output zero at once
	a_zero_low_fast: assert property ( // RULE3
		st.enable && !generator_signal_a |=> !output_zero
	) else $error("output zero stayed high after A fell");

	// Enabled, rise delay of three: high shows exactly three cycles late
	a_rise_delay_three: assert property ( // RULE3
		(st.enable && st.rise_dly == 12'h003 && $rose(generator_signal_a))
			##0 (st.enable && st.rise_dly == 12'h003 && generator_signal_a)[*4]
		|-> ##1 output_zero && $past(!output_zero)
	) else $error("rising edge not delayed by three cycles");

	// Enabled, fall delay of two: low shows exactly two cycles late
	a_fall_delay_two: assert property ( // RULE4
		(st.enable && st.fall_dly == 12'h002 && $fell(generator_signal_a))
			##0 (st.enable && st.fall_dly == 12'h002 && !generator_signal_a)[*3]
		|-> ##1 !output_one && $past(output_one)
	) else $error("falling edge not delayed by two cycles");

	// Disabled: a nonzero rise delay still lets A rise at once
	a_dis_no_delay: assert property ( // RULE8
		!st.enable && st.rise_dly != 12'h000 && $rose(generator_signal_a)
		|=> output_zero
	) else $error("rise delay acted while disabled");

	// A one-cycle high pulse under a longer delay never reaches output zero
	a_pulse_swallow: assert property ( // RULE9 RULE14
		st.enable && st.rise_dly > 12'h001 && $rose(generator_signal_a)
			##1 st.enable && !generator_signal_a
		|-> !output_zero ##1 !output_zero
	) else $error("short high pulse leaked through rise delay");

	// A one-cycle low pulse under a longer delay never reaches output one
	a_gap_swallow: assert property ( // RULE10 RULE14
		st.enable && st.fall_dly > 12'h001 && $fell(generator_signal_a)
			##1 st.enable && generator_signal_a
		|-> output_one ##1 output_one
	) else $error("short low pulse leaked through fall delay");

	// Control write then read returns only the enable bit
	a_ctl_readback: assert property ( // RULE5
		reg_wr && reg_addr == `PDB_CTL_OFF ##1 reg_rd && reg_addr == `PDB_CTL_OFF
		|=> reg_rdata == {`PDB_CTL_PAD, $past(reg_wdata[`PDB_EN_BIT], 2)}
	) else $error("control readback wrong");

	// Rise delay write then read returns the low twelve bits
	a_rise_readback: assert property ( // RULE6 RULE13
		reg_wr && reg_addr == `PDB_RISE_OFF ##1 reg_rd && reg_addr == `PDB_RISE_OFF
		|=> reg_rdata == {`PDB_DLY_PAD, $past(reg_wdata[`PDB_DLY_W-1:0], 2)}
	) else $error("rise delay readback wrong");

	// Fall delay write then read returns the low twelve bits
	a_fall_readback: assert property ( // RULE7 RULE13
		reg_wr && reg_addr == `PDB_FALL_OFF ##1 reg_rd && reg_addr == `PDB_FALL_OFF
		|=> reg_rdata == {`PDB_DLY_PAD, $past(reg_wdata[`PDB_DLY_W-1:0], 2)}
	) else $error("fall delay readback wrong");

	// Read data stands only in the cycle after a read
	a_rdata_idle: assert property (
		!reg_rd |=> reg_rdata == `PDB_RD_IDLE
	) else $error("read data present without a read");

	// ************************************************************
	// Coverage
	// ************************************************************
	c_delayed_rise: cover property (
		st.enable && st.rise_dly != 12'h000 && $rose(generator_signal_a)
		##[1:20] $rose(output_zero)
	);

	c_delayed_fall: cover property (
		st.enable && st.fall_dly != 12'h000 && $fell(generator_signal_a)
		##[1:20] $fell(output_one)
	);

	c_both_low_gap: cover property (
		st.enable && !output_zero && !output_one
	);

	c_enable_switch: cover property (
		!st.enable ##1 st.enable
	);

endmodule : pdb_dead_band

`default_nettype wire

// File: testbench/pdb_switch_model.sv
// Switch driver pair that loads the two dead-band outputs.
`default_nettype none

module pdb_switch_model (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic drv_zero,
	input  wire logic drv_one,
	output var  int   on_zero,
	output var  int   off_one
);
	timeunit 1ns;
	timeprecision 1ps;

	logic zero_q;
	logic one_q;

	// Count the turn-on events of output zero and the turn-off events of output one, as a real gate driver would see them
	always @(posedge clk) begin
		zero_q <= drv_zero;
		one_q  <= drv_one;
		if (rst) begin
			on_zero <= 0;
			off_one <= 0;
		end else begin
			if (drv_zero && !zero_q) on_zero <= on_zero + 1;
			if (!drv_one && one_q) off_one <= off_one + 1;
		end
	end
endmodule : pdb_switch_model

`default_nettype wire

// File: testbench/pdb_dead_band_tb.sv
// Self-checking bench for the dead-band generator.
`include "pdb_defines.svh"
`default_nettype none

module pdb_dead_band_tb;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int LIMIT = 20000;
	logic        clk   = 1'h0;
	logic        rst   = 1'h1;
	logic [11:0] addr  = 12'h000;
	logic [31:0] wdata = 32'h0;
	logic        wr    = 1'h0;
	logic        rd    = 1'h0;
	logic        a     = 1'h0;
	logic        b     = 1'h0;
	logic [31:0] rdata;
	logic        oz, oo, en_m, ez, eo;
	logic [11:0] rise_m, fall_m;
	int          on_zero, off_one, z0, o0, hi, lo, skip;
	int          fail_count  = 0;
	int          comparisons = 0;
	int          cyc         = 0;

	pdb_dead_band uut (.clk(clk), .rst(rst), .reg_addr(addr), .reg_wdata(wdata),
		.reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .generator_signal_a(a),
		.generator_signal_b(b), .output_zero(oz), .output_one(oo));
	pdb_switch_model load (.clk(clk), .rst(rst), .drv_zero(oz), .drv_one(oo),
		.on_zero(on_zero), .off_one(off_one));

	// ********
	// Checking
	// ********
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_reg

	task automatic chk_out(input logic [1:0] got, input logic [1:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_out

	task automatic results();
		$display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results

	function automatic logic [31:0] exp_rd(input logic [11:0] ad);
		case (ad)
			`PDB_CTL_OFF:  return {31'h0, en_m};
			`PDB_RISE_OFF: return {20'h0, rise_m};
			`PDB_FALL_OFF: return {20'h0, fall_m};
			default:       return 32'h0;
		endcase
	endfunction : exp_rd

	// Reference model; dwell counts run in both modes, as in the design
	always @(posedge clk) begin
		if (rst) begin
			hi = 0;
			lo = 0;
			skip = 3;
			en_m = 1'h0;
			rise_m = 12'h000;
			fall_m = 12'h000;
		end else begin
			hi = a ? hi + 1 : 0;
			lo = a ? 0 : lo + 1;
			ez = en_m ? (a && hi > rise_m) : a;
			eo = en_m ? (a || lo <= fall_m) : b;
			skip = (skip > 0) ? skip - 1 : 0;
			// Outputs at a config edge may use old or new values: not judged
			if (wr) begin
				skip = 2;
				if (addr == `PDB_CTL_OFF) en_m = wdata[0];
				if (addr == `PDB_RISE_OFF) rise_m = wdata[11:0];
				if (addr == `PDB_FALL_OFF) fall_m = wdata[11:0];
			end
		end
	end

	// Outputs judged every cycle, away from the edges
	always @(negedge clk) begin
		if (!rst && skip == 0)
			chk_out({oz, oo}, {ez, eo});
	end

	always #5 clk = ~clk;

	// B is noise every cycle, so an enabled block that uses it is caught
	always @(posedge clk) b <= 1'($urandom);

	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			fail_count++;
			results();
		end
	end

	// *********
	// Bus tasks
	// *********
	task automatic wr_reg(input logic [11:0] ad, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'h1;
		rd <= 1'h0;
		addr <= ad;
		wdata <= d;
	endtask : wr_reg

	// Read taken at the next edge; data stands only in the cycle after
	task automatic rd_reg(input logic [11:0] ad);
		@(posedge clk);
		rd <= 1'h1;
		wr <= 1'h0;
		addr <= ad;
		@(posedge clk);
		rd <= 1'h0;
		#1 chk_reg(rdata, exp_rd(ad));
	endtask : rd_reg

	// Reserved bits are always written as zero; each write is read back at once
	task automatic cfg(input logic e, input logic [11:0] r, input logic [11:0] f);
		wr_reg(`PDB_CTL_OFF, {31'h0, e});
		rd_reg(`PDB_CTL_OFF);
		wr_reg(`PDB_RISE_OFF, {20'h0, r});
		rd_reg(`PDB_RISE_OFF);
		wr_reg(`PDB_FALL_OFF, {20'h0, f});
		rd_reg(`PDB_FALL_OFF);
	endtask : cfg

	task automatic hold(input logic lvl, input int len);
		@(posedge clk);
		a <= lvl;
		repeat (len - 1) @(posedge clk);
	endtask : hold

	initial begin
		void'($urandom(32'hEBE7));
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		rd_reg(`PDB_CTL_OFF);
		rd_reg(`PDB_RISE_OFF);
		rd_reg(`PDB_FALL_OFF);
		wr_reg(12'h074, 32'hFFFFFFFF);
		rd_reg(12'h074);
		rd_reg(12'h069);
		rd_reg(`PDB_CTL_OFF);
		@(posedge clk);
		#1 chk_reg(rdata, 32'h0);
		// Even rounds pass through, odd rounds insert dead bands
		for (int r = 0; r < 8; r++) begin
			cfg(r[0], 12'($urandom_range(0, 9)), 12'($urandom_range(0, 9)));
			repeat (40) hold(~a, $urandom_range(1, 12));
		end
		// Pulses at and just past each delay
		cfg(1'h1, 12'h003, 12'h005);
		hold(1'h0, 20);
		z0 = on_zero;
		o0 = off_one;
		hold(1'h1, 3);
		hold(1'h0, 20);
		hold(1'h1, 4);
		hold(1'h0, 5);
		hold(1'h1, 20);
		hold(1'h0, 6);
		hold(1'h1, 20);
		hold(1'h0, 20);
		chk_reg(32'(on_zero - z0), 32'h3);
		chk_reg(32'(off_one - o0), 32'h3);
		// Reset in mid-run clears the registers
		@(posedge clk);
		rst <= 1'h1;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		rd_reg(`PDB_CTL_OFF);
		rd_reg(`PDB_FALL_OFF);
		results();
	end
endmodule : pdb_dead_band_tb

`default_nettype wire
